// ---- rtl/srd_pkg.sv ----
/*
   Shared constants of the sample-rate clock divider: register offsets,
   field positions, reset values and widths.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package srd_pkg;

   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int CHANNELS   = 8;
   localparam int TRIM_W     = 24;
   localparam int MOD_W      = 3;
   localparam int COUNT_W    = 12;
   localparam int PRE_W      = 2;
   localparam int RATIO_W    = 3;
   localparam int EVT_W      = 2;

   // ------------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] PRIMARY_CONFIG_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFS         = 8'h04;
   localparam logic [ADDR_W-1:0] CLEAR_OFS          = 8'h08;
   localparam logic [ADDR_W-1:0] ENABLE_OFS         = 8'h0C;
   localparam logic [ADDR_W-1:0] COUNT_OFS          = 8'h10;
   localparam logic [ADDR_W-1:0] OFFSET_TRIM_OFS    = 8'h40;
   localparam logic [ADDR_W-1:0] GAIN_TRIM_OFS      = 8'h60;
   localparam logic [ADDR_W-1:0] RESULT_OFS         = 8'h80;
   localparam logic [ADDR_W-1:0] BANK_MASK          = 8'hE0;

   // ------------------------------------------------------------------
   // fields of the primary config word
   // ------------------------------------------------------------------
   localparam int PRESCALE_LSB = 0;
   localparam int RATIO_LSB    = 2;

   // ------------------------------------------------------------------
   // status / clear / enable bit positions
   // ------------------------------------------------------------------
   localparam int EVT_DATA_READY = 0;
   localparam int EVT_OVERRUN    = 1;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [PRE_W-1:0]   PRESCALE_RESET = 2'h0;   // divide by one
   localparam logic [RATIO_W-1:0] RATIO_RESET    = 3'h3;   // ratio 256
   localparam logic [TRIM_W-1:0]  TRIM_RESET     = 24'h000000;

   // ------------------------------------------------------------------
   // division constants
   // ------------------------------------------------------------------
   localparam int SAMPLE_DIV    = 4;     // modulator ticks per sample
   localparam int RATIO_MIN_LOG = 5;     // code 0 selects 32
   localparam int GAIN_FRAC     = 23;    // gain trim is a Q1.23 fraction

endpackage

// ---- rtl/srd_channel.sv ----
/*
   One converter channel: first-order sinc decimator followed by the
   channel's own offset and gain correction.
   Assumes the modulator word is produced on clk and is valid whenever
   sampleTick is high; dumpTick coincides with the last sample of a period.
*/
`timescale 1ns/1ps
module srd_channel
   import srd_pkg::*;
(
   input  wire logic                         clk,
   input  wire logic                         resetn,
   input  wire logic                         sampleTick,
   input  wire logic                         dumpTick,
   input  wire logic signed [srd_pkg::MOD_W-1:0]  modData,
   input  wire logic signed [srd_pkg::TRIM_W-1:0] offsetTrim,
   input  wire logic signed [srd_pkg::TRIM_W-1:0] gainTrim,
   output logic signed [srd_pkg::TRIM_W-1:0]      result
);
   import srd_pkg::*;

   localparam logic signed [TRIM_W:0] MAX_POS = 25'sh07FFFFF;
   localparam logic signed [TRIM_W:0] MAX_NEG = -25'sh0800000;

   logic signed [TRIM_W-1:0]       acc_q, acc_d;
   logic signed [TRIM_W-1:0]       result_q, result_d;
   logic signed [TRIM_W-1:0]       raw;
   logic signed [TRIM_W:0]         shifted;
   logic signed [TRIM_W:0]         withOffset;
   logic signed [2*TRIM_W+1:0]     product;
   logic signed [TRIM_W+1:0]       corrected;

   // saturate a wide sum back into the 24-bit result range
   function automatic logic signed [TRIM_W-1:0] clip(
      input logic signed [TRIM_W+1:0] v);
      if (v > TRIM_W'(MAX_POS))
         return MAX_POS[TRIM_W-1:0];
      else if (v < (TRIM_W+2)'(MAX_NEG))
         return MAX_NEG[TRIM_W-1:0];
      else
         return v[TRIM_W-1:0];
   endfunction

   // ------------------------------------------------------------------
   // boxcar accumulate-and-dump
   // ------------------------------------------------------------------
   always_comb begin
      raw        = acc_q + TRIM_W'(modData);
      acc_d      = acc_q;
      if (sampleTick) begin
         acc_d = dumpTick ? '0 : raw;
      end
      withOffset = (TRIM_W+1)'(raw) + (TRIM_W+1)'(offsetTrim);
      shifted    = withOffset;
      // gain word is a signed fraction added to unity slope
      product    = (2*TRIM_W+2)'(shifted) * (2*TRIM_W+2)'(gainTrim);
      corrected  = (TRIM_W+2)'(shifted)
                 + (TRIM_W+2)'(product >>> GAIN_FRAC);
      result_d   = result_q;
      if (sampleTick && dumpTick) begin
         result_d = clip(corrected);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         acc_q    <= '0;
         result_q <= '0;
      end else begin
         acc_q    <= acc_d;
         result_q <= result_d;
      end
   end

   assign result = result_q;

endmodule // srd_channel

// ---- rtl/srd_clock_divider.sv ----
/*
   Sample-rate clock divider of an eight-channel delta-sigma front end,
   with per-channel offset and gain correction, reached over APB.
   Assumes clk is the master clock, modulator words arrive on clk, and
   the host watches sampleReadyN or the interrupt output.
*/
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module srd_clock_divider
   import srd_pkg::*;
#(
   parameter int NUM_CH = srd_pkg::CHANNELS
)(
   input  wire logic                             clk,
   input  wire logic                             resetn,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [srd_pkg::ADDR_W-1:0]       paddr,
   input  wire logic [srd_pkg::DATA_W-1:0]       pwdata,
   output logic      [srd_pkg::DATA_W-1:0]       prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire logic [NUM_CH*srd_pkg::MOD_W-1:0] modData,
   output logic                                  modulatorTick,
   output logic                                  sampleClock,
   output logic                                  sampleReadyN,
   output logic                                  irq
);
   import srd_pkg::*;

   // ------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------
   function automatic logic [COUNT_W-1:0] ratioLast(
      input logic [RATIO_W-1:0] sel);
      // shift amount needs four bits: code 7 plus five is twelve
      return COUNT_W'((13'h0001 << (4'(sel) + 4'(RATIO_MIN_LOG)))
                      - 13'h0001);
   endfunction

   function automatic logic [2:0] prescaleLast(
      input logic [PRE_W-1:0] sel);
      return 3'((4'h1 << sel) - 4'h1);
   endfunction

   function automatic logic inBank(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] base);
      return ((a & BANK_MASK) == base) && (a[1:0] == 2'h0)
             && (int'(a[4:2]) < NUM_CH);
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [PRE_W-1:0]        prescale_q, prescale_d;
   logic [RATIO_W-1:0]      ratio_q, ratio_d;
   logic [2:0]              preCnt_q, preCnt_d;
   logic [1:0]              phase_q, phase_d;
   logic [COUNT_W-1:0]      rateCnt_q, rateCnt_d;
   logic                    modTick_q, modTick_d;
   logic                    sampleClk_q, sampleClk_d;
   logic                    readyLow_q, readyLow_d;
   logic                    readyN_q, readyN_d;
   logic [EVT_W-1:0]        status_q, status_d;
   logic [EVT_W-1:0]        enable_q, enable_d;
   logic                    irq_q, irq_d;
   logic                    unread_q, unread_d;
   logic [TRIM_W-1:0]       offsetTrim_q [NUM_CH];
   logic [TRIM_W-1:0]       offsetTrim_d [NUM_CH];
   logic [TRIM_W-1:0]       gainTrim_q [NUM_CH];
   logic [TRIM_W-1:0]       gainTrim_d [NUM_CH];
   logic [DATA_W-1:0]       prdata_q, prdata_d;
   logic                    pready_q, pready_d;
   logic                    pslverr_q, pslverr_d;

   logic                    modTick;
   logic                    sampleTick;
   logic                    wrap;
   logic                    restart;
   logic                    access;
   logic                    wrEn;
   logic                    rdEn;
   logic [2:0]              chSel;
   logic [EVT_W-1:0]        events;
   logic [TRIM_W-1:0]       result [NUM_CH];

   assign access  = psel && penable && pready_q;
   assign wrEn    = access && pwrite;
   assign rdEn    = access && !pwrite;
   assign chSel   = paddr[4:2];
   assign restart = wrEn && (paddr == PRIMARY_CONFIG_OFS);

   // ------------------------------------------------------------------
   // divider chain
   // ------------------------------------------------------------------
   assign modTick    = (preCnt_q == prescaleLast(prescale_q));
   assign sampleTick = modTick && (phase_q == 2'(SAMPLE_DIV - 1));
   assign wrap       = sampleTick
                       && (rateCnt_q == ratioLast(ratio_q));

   always_comb begin
      preCnt_d    = modTick ? 3'h0 : preCnt_q + 3'h1;
      phase_d     = modTick ? phase_q + 2'h1 : phase_q;
      rateCnt_d   = rateCnt_q;
      if (sampleTick) begin
         rateCnt_d = wrap ? '0 : rateCnt_q + COUNT_W'(1);
      end
      readyLow_d  = readyLow_q;
      // low for the first half of the sample period after the wrap
      if (wrap) begin
         readyLow_d = 1'b1;
      end else if (modTick && phase_q == 2'h1) begin
         readyLow_d = 1'b0;
      end
      // a new setting restarts the chain so no short period escapes
      if (restart) begin
         preCnt_d   = 3'h0;
         phase_d    = 2'h0;
         rateCnt_d  = '0;
         readyLow_d = 1'b0;
      end
      modTick_d   = (preCnt_d == prescaleLast(prescale_d));
      sampleClk_d = !phase_d[1];
      readyN_d    = !readyLow_d;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         preCnt_q    <= 3'h0;
         phase_q     <= 2'h0;
         rateCnt_q   <= '0;
         readyLow_q  <= 1'b0;
         modTick_q   <= 1'b1;
         sampleClk_q <= 1'b1;
         readyN_q    <= 1'b1;
      end else begin
         preCnt_q    <= preCnt_d;
         phase_q     <= phase_d;
         rateCnt_q   <= rateCnt_d;
         readyLow_q  <= readyLow_d;
         modTick_q   <= modTick_d;
         sampleClk_q <= sampleClk_d;
         readyN_q    <= readyN_d;
      end
   end

   // ------------------------------------------------------------------
   // channels
   // ------------------------------------------------------------------
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      srd_channel u_ch (
         .clk        (clk),
         .resetn     (resetn),
         .sampleTick (sampleTick),
         .dumpTick   (wrap),
         .modData    (modData[ch*MOD_W +: MOD_W]),
         .offsetTrim (offsetTrim_q[ch]),
         .gainTrim   (gainTrim_q[ch]),
         .result     (result[ch])
      );
   end

   // ------------------------------------------------------------------
   // events and interrupt
   // ------------------------------------------------------------------
   always_comb begin
      events                 = '0;
      events[EVT_DATA_READY] = wrap;
      events[EVT_OVERRUN]    = wrap && unread_q;
      unread_d = unread_q;
      if (rdEn && inBank(paddr, RESULT_OFS)) begin
         unread_d = 1'b0;
      end
      if (wrap) begin
         unread_d = 1'b1;
      end
      status_d = status_q;
      if (wrEn && paddr == CLEAR_OFS) begin
         status_d = status_q & ~pwdata[EVT_W-1:0];
      end
      // a new event outranks a clear in the same cycle
      status_d = status_d | events;
      enable_d = enable_q;
      if (wrEn && paddr == ENABLE_OFS) begin
         enable_d = pwdata[EVT_W-1:0];
      end
      irq_d = |(status_d & enable_d);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_q <= '0;
         enable_q <= '0;
         irq_q    <= 1'b0;
         unread_q <= 1'b0;
      end else begin
         status_q <= status_d;
         enable_q <= enable_d;
         irq_q    <= irq_d;
         unread_q <= unread_d;
      end
   end

   // ------------------------------------------------------------------
   // configuration and trim words
   // ------------------------------------------------------------------
   always_comb begin
      prescale_d   = prescale_q;
      ratio_d      = ratio_q;
      offsetTrim_d = offsetTrim_q;
      gainTrim_d   = gainTrim_q;
      if (restart) begin
         prescale_d = pwdata[PRESCALE_LSB +: PRE_W];
         ratio_d    = pwdata[RATIO_LSB +: RATIO_W];
      end
      if (wrEn && inBank(paddr, OFFSET_TRIM_OFS)) begin
         offsetTrim_d[chSel] = pwdata[TRIM_W-1:0];
      end
      if (wrEn && inBank(paddr, GAIN_TRIM_OFS)) begin
         gainTrim_d[chSel] = pwdata[TRIM_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prescale_q <= PRESCALE_RESET;
         ratio_q    <= RATIO_RESET;
         for (int i = 0; i < NUM_CH; i++) begin
            offsetTrim_q[i] <= TRIM_RESET;
            gainTrim_q[i]   <= TRIM_RESET;
         end
      end else begin
         prescale_q   <= prescale_d;
         ratio_q      <= ratio_d;
         offsetTrim_q <= offsetTrim_d;
         gainTrim_q   <= gainTrim_d;
      end
   end

   // ------------------------------------------------------------------
   // APB slave, one wait state so every answer comes from a flop
   // ------------------------------------------------------------------
   always_comb begin
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      prdata_d  = '0;
      if (psel && penable && !pready_q) begin
         pready_d = 1'b1;
         if (paddr == PRIMARY_CONFIG_OFS) begin
            prdata_d[PRESCALE_LSB +: PRE_W] = prescale_q;
            prdata_d[RATIO_LSB +: RATIO_W]  = ratio_q;
         end else if (paddr == STATUS_OFS) begin
            prdata_d[EVT_W-1:0] = status_q;
         end else if (paddr == CLEAR_OFS) begin
            prdata_d = '0;
         end else if (paddr == ENABLE_OFS) begin
            prdata_d[EVT_W-1:0] = enable_q;
         end else if (paddr == COUNT_OFS) begin
            prdata_d[COUNT_W-1:0] = rateCnt_q;
         end else if (inBank(paddr, OFFSET_TRIM_OFS)) begin
            prdata_d[TRIM_W-1:0] = offsetTrim_q[chSel];
         end else if (inBank(paddr, GAIN_TRIM_OFS)) begin
            prdata_d[TRIM_W-1:0] = gainTrim_q[chSel];
         end else if (inBank(paddr, RESULT_OFS)) begin
            prdata_d = DATA_W'(signed'(result[chSel]));
         end else begin
            pslverr_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata_q  <= '0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign modulatorTick = modTick_q;
   assign sampleClock   = sampleClk_q;
   assign sampleReadyN  = readyN_q;
   assign irq           = irq_q;

endmodule // srd_clock_divider

// ---- testbench/srd_divider_monitor.sv ----
/* Assertion checker for the sample-rate clock divider.
   Assumes it is bound to srd_clock_divider and sees only its ports. */
`timescale 1ns/1ps
module srd_divider_monitor
   import srd_pkg::*;
(
   input wire logic                       clk,
   input wire logic                       resetn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [srd_pkg::ADDR_W-1:0] paddr,
   input wire logic [srd_pkg::DATA_W-1:0] pwdata,
   input wire logic [srd_pkg::DATA_W-1:0] prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       modulatorTick,
   input wire logic                       sampleClock,
   input wire logic                       sampleReadyN,
   input wire logic                       irq
);
   // ------------------------------------------------------------
   // shadow of config and enable, kept from completed writes
   // ------------------------------------------------------------
   logic [PRE_W-1:0]   pre_q, pre_d;
   logic [RATIO_W-1:0] rat_q, rat_d;
   logic               en_q, en_d, rdy_q, rdy_d, sc_q, sc_d, ok_q, ok_d;
   logic [17:0]        gap_q, gap_d, low_q, low_d, hi_q, hi_d, div, period;
   logic               wrDone, cfgWr, rdyFell, scFell;

   always_comb begin
      wrDone  = psel && penable && pready && pwrite && !pslverr;
      cfgWr   = wrDone && paddr == PRIMARY_CONFIG_OFS;
      rdyFell = rdy_q && !sampleReadyN;
      scFell  = sc_q && !sampleClock;
      div     = 18'h1 << pre_q;
      period  = 18'h4 << (int'(pre_q) + int'(rat_q) + RATIO_MIN_LOG);
      pre_d   = cfgWr ? pwdata[PRESCALE_LSB +: PRE_W] : pre_q;
      rat_d   = cfgWr ? pwdata[RATIO_LSB +: RATIO_W] : rat_q;
      en_d    = (wrDone && paddr == ENABLE_OFS) ?
                pwdata[EVT_DATA_READY] : en_q;
      rdy_d   = sampleReadyN;
      sc_d    = sampleClock;
      gap_d   = rdyFell ? 18'h1 : gap_q + 18'h1;
      low_d   = sampleReadyN ? 18'h0 : low_q + 18'h1;
      hi_d    = sampleClock ? hi_q + 18'h1 : 18'h0;
      // a restart breaks the running period, so judge only whole ones
      ok_d    = !cfgWr && (ok_q || rdyFell);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_q <= PRESCALE_RESET;
         rat_q <= RATIO_RESET;
         en_q  <= 1'b0;
         rdy_q <= 1'b1;
         sc_q  <= 1'b1;
         ok_q  <= 1'b0;
         gap_q <= 18'h0;
         low_q <= 18'h0;
         hi_q  <= 18'h0;
      end else begin
         pre_q <= pre_d;
         rat_q <= rat_d;
         en_q  <= en_d;
         rdy_q <= rdy_d;
         sc_q  <= sc_d;
         ok_q  <= ok_d;
         gap_q <= gap_d;
         low_q <= low_d;
         hi_q  <= hi_d;
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      penable && !pready ##1 penable && pready;
   endsequence

   a_one_wait: assert property (s_setup |=> s_access)
      else $error("apb answer not after one wait state");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_idle_rdata: assert property (!pready |-> prdata == '0)
      else $error("read data not zero outside answer");
   a_rate_period: assert property (rdyFell && ok_q |-> gap_q == period)
      else $error("ready period wrong");
   a_pulse_width: assert property ($rose(sampleReadyN) && ok_q |-> low_q == div * 2)
      else $error("ready pulse width wrong");
   a_sample_high: assert property (scFell && ok_q |-> hi_q == div * 2)
      else $error("sample clock high phase wrong");
   a_tick_full: assert property (pre_q == 2'h0 && $past(pre_q) == 2'h0 |-> modulatorTick)
      else $error("modulator tick not constant at divide by one");
   a_tick_pulse: assert property (modulatorTick && pre_q != 2'h0 && !cfgWr |=> !modulatorTick)
      else $error("modulator tick longer than one cycle");
   a_irq_follow: assert property (rdyFell && en_q |-> ##[1:2] irq)
      else $error("interrupt missing after ready");
   a_irq_masked: assert property (!en_q && !$past(en_q) |-> !irq)
      else $error("interrupt while disabled");
endmodule // srd_divider_monitor

bind srd_clock_divider srd_divider_monitor i_srd_divider_monitor (
   .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .modulatorTick(modulatorTick),
   .sampleClock(sampleClock), .sampleReadyN(sampleReadyN), .irq(irq));

// ---- testbench/srd_host_model.sv ----
/* Host model watching the active-low ready output.
   Assumes the ready line is a register on clk; counts pulses and gaps. */
`timescale 1ns/1ps
module srd_host_model (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic sampleReadyN,
   output int        pulses,
   output int        gap
);
   logic last_q;
   int   age_q;

   // the pin is not latched, so a pulse is caught on its edge only
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         last_q <= 1'b1;
         age_q  <= 0;
         pulses <= 0;
         gap    <= 0;
      end else begin
         last_q <= sampleReadyN;
         age_q  <= age_q + 1;
         if (last_q && !sampleReadyN) begin
            pulses <= pulses + 1;
            gap    <= age_q;
            age_q  <= 1;
         end
      end
   end
endmodule // srd_host_model

// ---- testbench/srd_clock_divider_bench.sv ----
/* Self-checking bench of the sample-rate clock divider.
   Assumes the design's APB timing and a host model on the ready line. */
`timescale 1ns/1ps
module srd_clock_divider_bench;
   import srd_pkg::*;
   logic                        clk, resetn, psel, penable, pwrite, err;
   logic                        pready, pslverr, irq;
   logic                        modulatorTick, sampleClock, sampleReadyN;
   logic [ADDR_W-1:0]           paddr;
   logic [DATA_W-1:0]           pwdata, prdata, rd;
   logic [CHANNELS*MOD_W-1:0]   modData;
   int                          nFail, nTests, pulses, gap;

   srd_clock_divider i_srd_clock_divider (.clk(clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .modData(modData), .modulatorTick(modulatorTick),
      .sampleClock(sampleClock), .sampleReadyN(sampleReadyN), .irq(irq));
   srd_host_model i_srd_host_model (.clk(clk), .resetn(resetn),
      .sampleReadyN(sampleReadyN), .pulses(pulses), .gap(gap));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         nFail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finalReport();
      $display("checks %0d mismatches %0d", nTests, nFail);
      if (nFail == 0 && nTests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) check(32'h0, 32'h1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic waitPulse();
      int start;
      int n;
      start = pulses;
      n = 0;
      while (pulses == start && n < 40000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40000) check(32'h0, 32'h1);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic testReset();
      check({31'h0, sampleReadyN}, 32'h1);
      apb(1'b0, PRIMARY_CONFIG_OFS, 32'h0);
      check(rd, 32'h0000000C);
      apb(1'b0, OFFSET_TRIM_OFS, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, GAIN_TRIM_OFS + 8'h1C, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'hFC, 32'h0);
      check({31'h0, err}, 32'h1);
      waitPulse();
      waitPulse();
      check(gap, 32'd1024);
   endtask

   task automatic testRate(input int pre, input int rat);
      int w;
      apb(1'b1, PRIMARY_CONFIG_OFS, 32'((rat << 2) | pre));
      waitPulse();
      waitPulse();
      check(gap, 32'(4 << (pre + rat + 5)));
      w = 1;
      while (sampleReadyN === 1'b0 && w < 100) begin
         w++;
         @(posedge clk);
      end
      check(w, 32'(2 << pre));
   endtask

   task automatic testIrq();
      apb(1'b1, PRIMARY_CONFIG_OFS, 32'h0);
      apb(1'b1, ENABLE_OFS, 32'h1);
      waitPulse();
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      apb(1'b0, STATUS_OFS, 32'h0);
      check(rd, 32'h3);
      apb(1'b1, CLEAR_OFS, 32'h1);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, ENABLE_OFS, 32'h0);
      waitPulse();
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      apb(1'b0, STATUS_OFS, 32'h0);
      check(rd, 32'h3);
   endtask

   // channel n sees the constant word n, read as 3-bit signed
   task automatic testTrim();
      int sv;
      apb(1'b1, PRIMARY_CONFIG_OFS, 32'h0);
      for (int n = 0; n < CHANNELS; n++) begin
         apb(1'b1, OFFSET_TRIM_OFS + 8'(n * 4), 32'(8 * n));
         apb(1'b1, GAIN_TRIM_OFS + 8'(n * 4), 32'(n) << 20);
      end
      waitPulse();
      waitPulse();
      for (int n = 0; n < CHANNELS; n++) begin
         sv = (n < 4) ? n : n - 8;
         apb(1'b0, RESULT_OFS + 8'(n * 4), 32'h0);
         check(rd, 32'((32 * sv + 8 * n) * (8 + n) / 8));
      end
   endtask

   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      modData = 24'hFAC688;
      nFail = 0;
      nTests = 0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      testReset();
      for (int p = 0; p < 4; p++) testRate(p, 0);
      for (int r = 1; r < 8; r++) testRate(0, r);
      testIrq();
      testTrim();
      finalReport();
   end

   // about 72k cycles expected; 95k means a hang
   initial begin
      #950000;
      nFail++;
      finalReport();
   end
endmodule // srd_clock_divider_bench
